// [rtl/mcf_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// [RL1] Repeat style: release interrupt 50 us, reassert.
// [RL2] Level style: interrupt stays while events pend.
// [RL3] Active bit low means standby, outputs off.
// [RL4] Dim timeout sets dim bit in hardware.
// [RL5] Host writing dim bit forces dim current.
// [RL6] Dim takes effect only with backlight enabled.
// [RL7] Gain hold: no gain down until sinks off.
// [RL8] Gain hold clear: gain follows demand freely.
// [RL9] Host sets hold for external loads, small capacitors.
// [RL10] Sync switch turns all independent sinks together.
// [RL11] Sync switch ignored if any per-sink enable.
// [RL12] Backlight on needs enable and active bits.
// [RL13] Output short detection sets short flag.
// [RL14] Die overtemperature sets thermal flag.
// [RL15] Output overvoltage sets overvoltage flag.
// [RL16] Flags clear only by writing one.
// [RL17] Flags stay set after fault disappears.
// [RL18] Reserved bits always read zero.
// [RL19] Reset or undervoltage returns all bits zero.
// [RL20] Enabled set flag raises interrupt output.
// ==========================================================================
// Mode control and fault status register bank.
// ==========================================================================
module mcf_regs
  import mcf_pkg::*;
#(
  parameter int unsigned BLANK = BLANK_CYCLES,
  parameter int          NSINK = 7
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              uvlo_i,
  input  wire logic              short_det_i,
  input  wire logic              overtemp_det_i,
  input  wire logic              ovp_det_i,
  input  wire logic [FLT_W-1:0]  irq_enable_i,
  input  wire logic              dim_timeout_i,
  input  wire logic [NSINK-1:0]  per_sink_indep_on_i,
  input  wire logic              gain_up_req_i,
  input  wire logic              gain_down_req_i,
  input  wire logic              all_sinks_off_i,
  output logic                   active_o,
  output logic                   backlight_on_o,
  output logic                   dim_o,
  output logic                   indep_sync_on_o,
  output logic      [1:0]        pump_gain_o,
  output logic                   irq_n_o
);

  // ========================================================================
  // Pin synchronisation.
  // ========================================================================
  logic [3:0]       det_s;
  logic             uvlo_s;
  logic [FLT_W-1:0] flt_det;

  mcf_sync #(
    .W (4)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({uvlo_i, short_det_i, overtemp_det_i, ovp_det_i}),
    .level_o   (det_s)
  );

  // Split the filtered levels into undervoltage and fault detections.
  assign uvlo_s  = det_s[3];
  assign flt_det = det_s[2:0];

  // ========================================================================
  // Register decode.
  // ========================================================================
  logic [DATA_W-1:0] mode_q;
  logic [FLT_W-1:0]  flags_q;
  logic [FLT_W-1:0]  next_flags;
  logic [FLT_W-1:0]  clr_bits;
  logic              wr_mode;
  logic              wr_fault;

  // Write strobes for the two registers.
  assign wr_mode  = reg_wr_i && (reg_addr_i == MODE_ADDR);
  assign wr_fault = reg_wr_i && (reg_addr_i == FAULT_ADDR);

  // Read word for an address; unmapped and reserved bits read zero.
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] mode,
    input logic [FLT_W-1:0]  flags
  );
    logic [DATA_W-1:0] w;
    w = '0;
    if (addr == MODE_ADDR) begin
      w = mode & MODE_MASK; // RL18
    end else if (addr == FAULT_ADDR) begin
      w[FLT_LSB +: FLT_W] = flags; // RL18
    end
    return w;
  endfunction : read_word

  // ========================================================================
  // Operating mode control register.
  // ========================================================================
  // The hardware dim set comes last so that it wins over a host write.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= MODE_RESET;
    end else if (uvlo_s) begin
      mode_q <= MODE_RESET; // RL19
    end else begin
      if (wr_mode) begin
        mode_q <= reg_wdata_i & MODE_MASK; // RL5
      end
      if (dim_timeout_i) begin
        mode_q[DIM_BIT] <= 1'b1; // RL4
      end
    end
  end

  // ========================================================================
  // Fault flag status register.
  // ========================================================================
  // Write one to clear; a standing detection wins over the clear.
  always_comb begin
    clr_bits   = wr_fault ? reg_wdata_i[FLT_LSB +: FLT_W] : '0;
    next_flags = (flags_q & ~clr_bits) | flt_det; // RL13 RL14 RL15 RL16
    if (uvlo_s) begin
      next_flags = FAULT_RESET; // RL19
    end
  end

  // Flags are sticky until cleared by the host or by undervoltage.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= FAULT_RESET;
    end else begin
      flags_q <= next_flags; // RL17
    end
  end

  // ========================================================================
  // Read data.
  // ========================================================================
  // Read data is captured on the read strobe and held until the next one.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_word(reg_addr_i, mode_q, flags_q);
    end
  end

  // ========================================================================
  // Sink enables.
  // ========================================================================
  logic next_active;
  logic next_bl;
  logic next_dim;
  logic next_sync;

  // Sink outputs and pump gain are idle in standby; flags and interrupt still run.
  always_comb begin
    next_active = mode_q[ACTIVE_BIT]; // RL3
    next_bl     = next_active && mode_q[BL_BIT]; // RL12
    next_dim    = next_bl && mode_q[DIM_BIT]; // RL6
    next_sync   = next_active && mode_q[SYNC_BIT]
                  && !(|per_sink_indep_on_i); // RL10 RL11
  end

  // Registered sink control outputs.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_o        <= 1'b0;
      backlight_on_o  <= 1'b0;
      dim_o           <= 1'b0;
      indep_sync_on_o <= 1'b0;
    end else begin
      active_o        <= next_active;
      backlight_on_o  <= next_bl;
      dim_o           <= next_dim;
      indep_sync_on_o <= next_sync;
    end
  end

  // ========================================================================
  // Charge pump gain policy.
  // ========================================================================
  mcf_gain_t gain_q;
  mcf_gain_t next_gain;
  logic      down_ok;

  // With the hold bit set, gain only steps down once every sink is off.
  always_comb begin
    down_ok   = !mode_q[HOLD_BIT] || all_sinks_off_i; // RL7 RL8
    next_gain = gain_q;
    if (!next_active) begin
      next_gain = MCF_GAIN_1X; // RL3
    end else if (gain_up_req_i) begin
      case (gain_q)
        MCF_GAIN_1X:   next_gain = MCF_GAIN_1P5X;
        MCF_GAIN_1P5X: next_gain = MCF_GAIN_2X;
        MCF_GAIN_2X:   next_gain = MCF_GAIN_2X;
        default:       next_gain = MCF_GAIN_1X;
      endcase
    end else if (gain_down_req_i && down_ok) begin
      case (gain_q)
        MCF_GAIN_2X:   next_gain = MCF_GAIN_1P5X;
        MCF_GAIN_1P5X: next_gain = MCF_GAIN_1X;
        MCF_GAIN_1X:   next_gain = MCF_GAIN_1X;
        default:       next_gain = MCF_GAIN_1X;
      endcase
    end
  end

  // Gain state register.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gain_q <= MCF_GAIN_1X;
    end else begin
      gain_q <= next_gain;
    end
  end

  assign pump_gain_o = gain_q;

  // ========================================================================
  // Interrupt generation.
  // ========================================================================
  mcf_irq_if irq_bus ();

  // Pending is taken from the next flag value so a clear is seen at once.
  assign irq_bus.pending_after = |(next_flags & irq_enable_i); // RL20
  assign irq_bus.clear_try     = wr_fault
                                 && (|reg_wdata_i[FLT_LSB +: FLT_W]);
  assign irq_bus.style_repeat  = mode_q[REPEAT_BIT];

  mcf_irq_gen #(
    .BLANK (BLANK)
  ) u_irq (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bus       (irq_bus.gen)
  );

  assign irq_n_o = irq_bus.irq_n;

  // ========================================================================
  // Checks.
  // ========================================================================
  property p_rsvd;
    @(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i |=> ($past(reg_addr_i) == MODE_ADDR) ? (reg_rdata_o[7] == 1'b0
      && reg_rdata_o[1] == 1'b0)
      : (reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[1:0] == 2'h0);
  endproperty
  a_rsvd: assert property (p_rsvd) // RL18
    else $error("Reserved bit read as one.");

  property p_stby;
    @(posedge sys_clk_i) disable iff (rst_i)
    !mode_q[ACTIVE_BIT] |=> (!backlight_on_o && !dim_o
      && !indep_sync_on_o && !active_o);
  endproperty
  a_stby: assert property (p_stby) // RL3
    else $error("Sinks on in standby.");

  property p_bl;
    @(posedge sys_clk_i) disable iff (rst_i)
    backlight_on_o |-> $past(mode_q[BL_BIT]) && $past(mode_q[ACTIVE_BIT]);
  endproperty
  a_bl: assert property (p_bl) // RL12
    else $error("Backlight on without enable and active.");

  property p_dim_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
    dim_o |-> backlight_on_o;
  endproperty
  a_dim_gate: assert property (p_dim_gate) // RL6
    else $error("Dim without backlight.");

  property p_dim_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    (dim_timeout_i && !uvlo_s) |=> mode_q[DIM_BIT];
  endproperty
  a_dim_set: assert property (p_dim_set) // RL4
    else $error("Dim timeout did not set dim bit.");

  property p_flag_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    (|flt_det && !uvlo_s) |=> ((flags_q & $past(flt_det))
      == $past(flt_det));
  endproperty
  a_flag_set: assert property (p_flag_set) // RL13 RL14 RL15
    else $error("Detected fault did not set its flag.");

  property p_flag_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!uvlo_s && !wr_fault) |=> ((flags_q & $past(flags_q))
      == $past(flags_q));
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RL16 RL17
    else $error("Flag lost without a clearing write.");

  property p_uvlo;
    @(posedge sys_clk_i) disable iff (rst_i)
    uvlo_s |=> (mode_q == MODE_RESET && flags_q == FAULT_RESET);
  endproperty
  a_uvlo: assert property (p_uvlo) // RL19
    else $error("Undervoltage did not clear registers.");

  property p_gain_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (mode_q[HOLD_BIT] && !all_sinks_off_i && mode_q[ACTIVE_BIT])
      |=> (gain_q >= $past(gain_q));
  endproperty
  a_gain_hold: assert property (p_gain_hold) // RL7
    else $error("Gain stepped down while held.");

  property p_sync_ign;
    @(posedge sys_clk_i) disable iff (rst_i)
    (|per_sink_indep_on_i) |=> !indep_sync_on_o;
  endproperty
  a_sync_ign: assert property (p_sync_ign) // RL11
    else $error("Sync switch acted with per-sink enables.");

endmodule : mcf_regs

// [rtl/mcf_pkg.sv]
// ==========================================================================
// Shared constants for the mode control and fault status register pair.
// ==========================================================================
package mcf_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] MODE_ADDR  = 8'h01;
  localparam logic [7:0] FAULT_ADDR = 8'h02;

  // Operating mode control field positions.
  localparam int REPEAT_BIT = 6;
  localparam int ACTIVE_BIT = 5;
  localparam int DIM_BIT    = 4;
  localparam int HOLD_BIT   = 3;
  localparam int SYNC_BIT   = 2;
  localparam int BL_BIT     = 0;

  // Fault flag field: short at 4, overtemperature at 3, overvoltage at 2.
  localparam int FLT_LSB = 2;
  localparam int FLT_W   = 3;

  // Writable masks and values after reset.
  localparam logic [7:0] MODE_MASK   = 8'h7D;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [2:0] FAULT_RESET = 3'h0;

  // Interrupt release time after a clear with events still pending.
  localparam int BLANK_TIME_US = 50;
  localparam int CLK_FREQ_MHZ  = 100;
  localparam int BLANK_CYCLES  = BLANK_TIME_US * CLK_FREQ_MHZ;

  // Number of flip-flops in each pin synchroniser.
  localparam int SYNC_STAGES = 3;

  // Charge pump gain steps, Gray coded along the up path.
  typedef enum logic [1:0] {
    MCF_GAIN_1X   = 2'h0,
    MCF_GAIN_1P5X = 2'h1,
    MCF_GAIN_2X   = 2'h3
  } mcf_gain_t;

endpackage : mcf_pkg

// [rtl/mcf_irq_if.sv]
`timescale 1ns/1ps
// ==========================================================================
// Carrier between the register bank and the interrupt generator.
// ==========================================================================
interface mcf_irq_if;
  logic pending_after;
  logic clear_try;
  logic style_repeat;
  logic irq_n;

  modport ctl (output pending_after, output clear_try,
               output style_repeat, input irq_n);
  modport gen (input pending_after, input clear_try,
               input style_repeat, output irq_n);
endinterface : mcf_irq_if

// [rtl/mcf_sync.sv]
`timescale 1ns/1ps
// ==========================================================================
// Three-stage pin synchroniser with agreement filter.
// ==========================================================================
module mcf_sync
  import mcf_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic [SYNC_STAGES-1:0] stage;
      // The output only moves once the last two stages agree.
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          stage      <= '0;
          level_o[g] <= 1'b0;
        end else begin
          stage <= {stage[SYNC_STAGES-2:0], pin_i[g]};
          if (stage[1] == stage[2]) begin
            level_o[g] <= stage[2];
          end
        end
      end
    end
  endgenerate

endmodule : mcf_sync

// [rtl/mcf_irq_gen.sv]
`timescale 1ns/1ps
// ==========================================================================
// Interrupt output generator with optional release window.
// ==========================================================================
module mcf_irq_gen
  import mcf_pkg::*;
#(
  parameter int unsigned BLANK = BLANK_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  mcf_irq_if.gen    bus
);

  localparam int CW = $clog2(BLANK + 1);

  logic [CW-1:0] blank_cnt;
  logic [CW-1:0] next_cnt;
  logic          start_blank;

  // A clear with events left over opens a release window in repeat style.
  always_comb begin
    start_blank = bus.clear_try && bus.style_repeat && bus.pending_after;
    if (start_blank) begin
      next_cnt = CW'(BLANK); // RL1
    end else if (blank_cnt != '0) begin
      next_cnt = blank_cnt - 1'b1;
    end else begin
      next_cnt = '0;
    end
  end

  // Release window counter.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blank_cnt <= '0;
    end else begin
      blank_cnt <= next_cnt;
    end
  end

  // Active low request, held low while an enabled flag stands and no release window runs.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.irq_n <= 1'b1;
    end else begin
      bus.irq_n <= ~(bus.pending_after && next_cnt == '0); // RL2 RL20
    end
  end

  property p_blank;
    @(posedge sys_clk_i) disable iff (rst_i)
    start_blank |=> bus.irq_n [*8];
  endproperty
  a_blank: assert property (p_blank) // RL1
    else $error("Interrupt not released after clear.");

  property p_stay;
    @(posedge sys_clk_i) disable iff (rst_i)
    (bus.clear_try && !bus.style_repeat && bus.pending_after)
      |=> !bus.irq_n;
  endproperty
  a_stay: assert property (p_stay) // RL2
    else $error("Interrupt dropped in level style.");

  property p_raise;
    @(posedge sys_clk_i) disable iff (rst_i)
    (bus.pending_after && !start_blank && blank_cnt == '0)
      |=> !bus.irq_n;
  endproperty
  a_raise: assert property (p_raise) // RL20
    else $error("Enabled flag did not raise interrupt.");

endmodule : mcf_irq_gen

// [test/mcf_host_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// Host processor model driving the register port of the register bank.
// ==========================================================================
module mcf_host_model
  import mcf_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic [DATA_W-1:0] reg_rdata_i,
  output logic                   reg_wr_o,
  output logic                   reg_rd_o,
  output logic      [ADDR_W-1:0] reg_addr_o,
  output logic      [DATA_W-1:0] reg_wdata_o
);
  // The idle bus shows the inverse of the last address; only a write inverts the data.
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One write strobe per word, launched and released on falling edges.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_i);
    reg_wr_o    = 1'b1;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    @(negedge sys_clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask : write_reg

  // Read strobe; the data is taken at the falling edge that follows the read edge.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge sys_clk_i);
    reg_rd_o   = 1'b1;
    reg_addr_o = addr;
    @(negedge sys_clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    data       = reg_rdata_i;
  endtask : read_reg
endmodule : mcf_host_model

// [test/mcf_regs_tb.sv]
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the mode control and fault status registers.
// ==========================================================================
module mcf_regs_tb;
  import mcf_pkg::*;

  localparam int BLANK_TB = 16;

  logic        sys_clk_i;
  logic        rst_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  logic        uvlo_i;
  logic [2:0]  det;
  logic [2:0]  irq_enable_i;
  logic        dim_timeout_i;
  logic [6:0]  per_sink_indep_on_i;
  logic        gain_up_req_i;
  logic        gain_down_req_i;
  logic        all_sinks_off_i;
  logic        active_o;
  logic        backlight_on_o;
  logic        dim_o;
  logic        indep_sync_on_o;
  logic [1:0]  pump_gain_o;
  logic        irq_n_o;
  logic [7:0]  rd;
  int          failures;
  int          num_checks;
  int          cycles;
  int          high_cnt;

  typedef struct {
    logic [7:0] wdata;
    logic [7:0] exp_rd;
    logic [3:0] exp_out;
  } mcf_row_t;

  // Mode writes: readback and {active, backlight, dim, sync} outputs.
  mcf_row_t rows [8] = '{
    '{8'h21, 8'h21, 4'hC}, '{8'h31, 8'h31, 4'hE},
    '{8'h11, 8'h11, 4'h0}, '{8'h30, 8'h30, 4'h8},
    '{8'h24, 8'h24, 4'h9}, '{8'h04, 8'h04, 4'h0},
    '{8'hFF, 8'h7D, 4'hF}, '{8'h00, 8'h00, 4'h0}};

  mcf_regs #(.BLANK(BLANK_TB), .NSINK(7)) mcf_regs_i (
    .sys_clk_i           (sys_clk_i),
    .rst_i               (rst_i),
    .reg_wr_i            (reg_wr_i),
    .reg_rd_i            (reg_rd_i),
    .reg_addr_i          (reg_addr_i),
    .reg_wdata_i         (reg_wdata_i),
    .reg_rdata_o         (reg_rdata_o),
    .uvlo_i              (uvlo_i),
    .short_det_i         (det[2]),
    .overtemp_det_i      (det[1]),
    .ovp_det_i           (det[0]),
    .irq_enable_i        (irq_enable_i),
    .dim_timeout_i       (dim_timeout_i),
    .per_sink_indep_on_i (per_sink_indep_on_i),
    .gain_up_req_i       (gain_up_req_i),
    .gain_down_req_i     (gain_down_req_i),
    .all_sinks_off_i     (all_sinks_off_i),
    .active_o            (active_o),
    .backlight_on_o      (backlight_on_o),
    .dim_o               (dim_o),
    .indep_sync_on_o     (indep_sync_on_o),
    .pump_gain_o         (pump_gain_o),
    .irq_n_o             (irq_n_o)
  );

  mcf_host_model mcf_host_model_i (
    .sys_clk_i   (sys_clk_i),
    .reg_rdata_i (reg_rdata_o),
    .reg_wr_o    (reg_wr_i),
    .reg_rd_o    (reg_rd_i),
    .reg_addr_o  (reg_addr_i),
    .reg_wdata_o (reg_wdata_i)
  );

  // ==========================================================================
  // Clock, timeout and reporting.
  // ==========================================================================
  // Free-running 100 MHz clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Cuts a hang short after far more cycles than the tests need.
  always @(posedge sys_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      final_report();
    end
  end

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : wait_cyc

  task automatic outs_check(input logic [3:0] exp);
    check("outputs", {4'h0, exp},
          {4'h0, active_o, backlight_on_o, dim_o, indep_sync_on_o});
  endtask : outs_check

  // Holds a detector pattern long enough to pass the pin synchroniser.
  task automatic fault_pulse(input logic [2:0] pat);
    det = pat;
    wait_cyc(6);
    det = 3'h0;
    wait_cyc(6);
  endtask : fault_pulse

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    failures = 0;
    num_checks = 0;
    cycles = 0;
    rst_i = 1'b1;
    uvlo_i = 1'b0;
    det = 3'h0;
    irq_enable_i = 3'h7;
    dim_timeout_i = 1'b0;
    per_sink_indep_on_i = 7'h00;
    gain_up_req_i = 1'b0;
    gain_down_req_i = 1'b0;
    all_sinks_off_i = 1'b0;
    wait_cyc(20);
    rst_i = 1'b0;
    outs_check(4'h0);
    check("irq_n", 8'h01, {7'h00, irq_n_o});
    mcf_host_model_i.read_reg(MODE_ADDR, rd);
    check("mode", 8'h00, rd);
    mcf_host_model_i.read_reg(FAULT_ADDR, rd);
    check("fault", 8'h00, rd);
    $display("reset test done");

    // Table of mode writes and the outputs that they give.
    foreach (rows[i]) begin
      mcf_host_model_i.write_reg(MODE_ADDR, rows[i].wdata);
      wait_cyc(1);
      outs_check(rows[i].exp_out);
      mcf_host_model_i.read_reg(MODE_ADDR, rd);
      check("mode", rows[i].exp_rd, rd);
    end
    $display("mode table test done");

    // Sync switch is ignored while a per-sink enable is set.
    mcf_host_model_i.write_reg(MODE_ADDR, 8'h24);
    per_sink_indep_on_i = 7'h40;
    wait_cyc(2);
    outs_check(4'h8);
    per_sink_indep_on_i = 7'h00;
    // Hardware dim timeout sets the dim bit.
    mcf_host_model_i.write_reg(MODE_ADDR, 8'h21);
    dim_timeout_i = 1'b1;
    wait_cyc(1);
    dim_timeout_i = 1'b0;
    wait_cyc(1);
    outs_check(4'hE);
    mcf_host_model_i.read_reg(MODE_ADDR, rd);
    check("mode", 8'h31, rd);
    // Unmapped address: write ignored, read gives zero.
    mcf_host_model_i.write_reg(8'h05, 8'hFF);
    mcf_host_model_i.read_reg(8'h05, rd);
    check("unmapped", 8'h00, rd);
    $display("dim and sync test done");

    // Pump gain follows demand, then is held up by the hold bit.
    mcf_host_model_i.write_reg(MODE_ADDR, 8'h21);
    gain_up_req_i = 1'b1;
    wait_cyc(2);
    gain_up_req_i = 1'b0;
    wait_cyc(1);
    check("gain", {6'h00, MCF_GAIN_2X}, {6'h00, pump_gain_o});
    gain_down_req_i = 1'b1;
    wait_cyc(1);
    gain_down_req_i = 1'b0;
    wait_cyc(1);
    check("gain", {6'h00, MCF_GAIN_1P5X}, {6'h00, pump_gain_o});
    mcf_host_model_i.write_reg(MODE_ADDR, 8'h29);
    gain_down_req_i = 1'b1;
    wait_cyc(3);
    check("gain", {6'h00, MCF_GAIN_1P5X}, {6'h00, pump_gain_o});
    all_sinks_off_i = 1'b1;
    wait_cyc(3);
    gain_down_req_i = 1'b0;
    all_sinks_off_i = 1'b0;
    check("gain", {6'h00, MCF_GAIN_1X}, {6'h00, pump_gain_o});
    $display("gain test done");

    // Each fault flag: set, sticky, immune to 0 and read, cleared by 1.
    for (int i = 0; i < 3; i++) begin
      fault_pulse(3'h1 << i);
      check("irq_n", 8'h00, {7'h00, irq_n_o});
      mcf_host_model_i.write_reg(FAULT_ADDR, 8'h00);
      mcf_host_model_i.read_reg(FAULT_ADDR, rd);
      mcf_host_model_i.read_reg(FAULT_ADDR, rd);
      check("fault", 8'h04 << i, rd);
      mcf_host_model_i.write_reg(FAULT_ADDR, 8'hFF);
      mcf_host_model_i.read_reg(FAULT_ADDR, rd);
      check("fault", 8'h00, rd);
      check("irq_n", 8'h01, {7'h00, irq_n_o});
    end
    // Masked flag still sets but raises no interrupt.
    irq_enable_i = 3'h0;
    fault_pulse(3'h2);
    check("irq_n", 8'h01, {7'h00, irq_n_o});
    mcf_host_model_i.read_reg(FAULT_ADDR, rd);
    check("fault", 8'h08, rd);
    mcf_host_model_i.write_reg(FAULT_ADDR, 8'h08);
    irq_enable_i = 3'h7;
    $display("fault flag test done");

    // Repeat style: clear with an event pending releases for BLANK cycles.
    mcf_host_model_i.write_reg(MODE_ADDR, 8'h60);
    fault_pulse(3'h5);
    mcf_host_model_i.write_reg(FAULT_ADDR, 8'h10);
    high_cnt = 0;
    // The window opens at the clearing edge, so sample before waiting.
    repeat (BLANK_TB + 8) begin
      if (irq_n_o === 1'b1) high_cnt = high_cnt + 1;
      @(negedge sys_clk_i);
    end
    check("release", 8'(BLANK_TB), 8'(high_cnt));
    check("irq_n", 8'h00, {7'h00, irq_n_o});
    // Level style: the interrupt stays asserted through the clear.
    mcf_host_model_i.write_reg(MODE_ADDR, 8'h20);
    fault_pulse(3'h4);
    mcf_host_model_i.write_reg(FAULT_ADDR, 8'h10);
    high_cnt = 0;
    repeat (BLANK_TB + 8) begin
      if (irq_n_o === 1'b1) high_cnt = high_cnt + 1;
      @(negedge sys_clk_i);
    end
    check("release", 8'h00, 8'(high_cnt));
    $display("interrupt style test done");

    // Undervoltage event returns both registers to zero.
    mcf_host_model_i.write_reg(MODE_ADDR, 8'h7D);
    uvlo_i = 1'b1;
    wait_cyc(8);
    uvlo_i = 1'b0;
    wait_cyc(2);
    mcf_host_model_i.read_reg(MODE_ADDR, rd);
    check("mode", 8'h00, rd);
    mcf_host_model_i.read_reg(FAULT_ADDR, rd);
    check("fault", 8'h00, rd);
    $display("undervoltage test done");
    final_report();
  end
endmodule : mcf_regs_tb
